// file: cpc_pkg.sv
// package: field layouts, register map and constants of the capability permission codec
package cpc_pkg;

    // permission set carrier, one bit per architectural grant
    typedef struct packed {
        logic sysreg_access_grant;
        logic execute_grant;
        logic store_local_grant;
        logic load_global_grant;
        logic load_mutable_grant;
        logic cap_transfer_grant;
        logic store_grant;
        logic load_grant;
    } cpc_perm_t;

    // decoded arch_perm_field
    typedef struct packed {
        logic reserved;
        logic execution_mode_flag;
        cpc_perm_t perms;
    } cpc_dec_t;

    // field widths
    localparam int AP_W = 5;
    localparam int SWP_W = 2;
    localparam int TYPE_W = 1;
    localparam int MANT_W = 10;
    localparam int BND_W = 24;
    localparam int ADDR_W = 12;
    localparam logic [7:0] MANT_WIDTH = 8'h0A;
    localparam logic [7:0] EXP_MAX = 8'h18;

    // quadrants of arch_perm_field[4:3]
    localparam logic [1:0] QUAD_DATA = 2'h0;
    localparam logic [1:0] QUAD_EXEC = 2'h1;
    localparam logic [1:0] QUAD_RCAP = 2'h2;
    localparam logic [1:0] QUAD_CAP = 2'h3;

    // permission sets, order {asr,x,sl,lg,lm,c,w,r}
    localparam logic [7:0] PS_NONE = 8'h00;
    localparam logic [7:0] PS_Q0_R = 8'h01;
    localparam logic [7:0] PS_Q0_W = 8'h02;
    localparam logic [7:0] PS_Q0_RW = 8'h03;
    localparam logic [7:0] PS_Q1_ALL = 8'hFF;
    localparam logic [7:0] PS_Q1_RO = 8'h5D;
    localparam logic [7:0] PS_Q1_RW = 8'h7F;
    localparam logic [7:0] PS_Q1_DRW = 8'h43;
    localparam logic [7:0] PS_Q2_RO = 8'h05;
    localparam logic [7:0] PS_Q2_RWSL = 8'h2F;
    localparam logic [7:0] PS_Q2_RW = 8'h0F;
    localparam logic [7:0] PS_Q3_RO = 8'h1D;
    localparam logic [7:0] PS_Q3_RWSL = 8'h3F;
    localparam logic [7:0] PS_Q3_RW = 8'h1F;

    // special capability encodings
    localparam logic [4:0] AP_INF = 5'h08;
    localparam logic [4:0] AP_INF_HYB = 5'h09;
    localparam logic [1:0] SWP_ONES = 2'h3;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CAP_PERM = 12'h004;
    localparam logic [11:0] OFS_CAP_BOUNDS = 12'h008;
    localparam logic [11:0] OFS_CAP_ADDR = 12'h00C;
    localparam logic [11:0] OFS_RESTRICT_MASK = 12'h010;
    localparam logic [11:0] OFS_READ_RESULT = 12'h014;
    localparam logic [11:0] OFS_RESTRICT_RESULT = 12'h018;
    localparam logic [11:0] OFS_STATUS = 12'h01C;
    localparam logic [11:0] OFS_FORMAT = 12'h020;
    localparam logic [11:0] OFS_INF_CONST = 12'h024;

    // reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_CAP_PERM = 32'h0000_0000;
    localparam logic [31:0] RST_CAP_BOUNDS = 32'h0000_0000;
    localparam logic [31:0] RST_CAP_ADDR = 32'h0000_0000;
    localparam logic [31:0] RST_RESTRICT_MASK = 32'h0000_07FF;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage

// file: cpc_top.sv
// capability permission codec: decode, restrict and encode over an APB register file
`timescale 1ns/10ps
// Function
// - five-bit field: quadrant high, entry low
// - quadrant 0: none, load, store, both
// - quadrant 1 entry bit 0 is mode
// - quadrant 1 entries 0-1 all, 4-5 no sysreg
// - quadrant 1 entries 2-3 read-only, 6-7 data
// - restricted quadrant entry 3: load, cap transfer
// - restricted entries 6, 7 with/without store local
// - capability quadrant entries 3, 6, 7
// - reserved encodings read as no permissions
// - restrict legality steps one to five in order
// - clear load mutable, then load global
// - store local needs load mutable and store
// - execute kept only in three combinations
// - clear sysreg access, then mode flag
// - mode one invalid without hybrid mode
// - software permissions two bits, read unchanged
// - type field is one bit
// - ten-bit mantissa, extra top reconstruction bit
// - null capability is all zero fields
// - infinite capability: tag, ones, 0x8
// - hybrid infinite capability uses 0x9
// - infinite regardless of address value
// - extension permissions granted when infinite
module cpc_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cpc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import cpc_pkg::*;

    // decode one encoding
    function automatic cpc_dec_t cpc_decode(input logic [AP_W-1:0] ap, input logic hyb);
        cpc_dec_t d;
        d = '0;
        unique case (ap[4:3])
            QUAD_DATA: begin
                case (ap[2:0])
                    3'h0: d.perms = cpc_perm_t'(PS_NONE);
                    3'h1: d.perms = cpc_perm_t'(PS_Q0_R);
                    3'h4: d.perms = cpc_perm_t'(PS_Q0_W);
                    3'h5: d.perms = cpc_perm_t'(PS_Q0_RW);
                    default: d.reserved = 1'b1;
                endcase
            end
            QUAD_EXEC: begin
                d.execution_mode_flag = ap[0];
                unique case (ap[2:1])
                    2'h0: d.perms = cpc_perm_t'(PS_Q1_ALL);
                    2'h1: d.perms = cpc_perm_t'(PS_Q1_RO);
                    2'h2: d.perms = cpc_perm_t'(PS_Q1_RW);
                    2'h3: d.perms = cpc_perm_t'(PS_Q1_DRW);
                endcase
                if (ap[0] && !hyb) begin
                    d.reserved = 1'b1;
                end
            end
            QUAD_RCAP: begin
                case (ap[2:0])
                    3'h3: d.perms = cpc_perm_t'(PS_Q2_RO);
                    3'h6: d.perms = cpc_perm_t'(PS_Q2_RWSL);
                    3'h7: d.perms = cpc_perm_t'(PS_Q2_RW);
                    default: d.reserved = 1'b1;
                endcase
            end
            QUAD_CAP: begin
                case (ap[2:0])
                    3'h3: d.perms = cpc_perm_t'(PS_Q3_RO);
                    3'h6: d.perms = cpc_perm_t'(PS_Q3_RWSL);
                    3'h7: d.perms = cpc_perm_t'(PS_Q3_RW);
                    default: d.reserved = 1'b1;
                endcase
            end
        endcase
        if (d.reserved) begin
            d.perms = cpc_perm_t'(PS_NONE);
            d.execution_mode_flag = 1'b0;
        end
        return d;
    endfunction

    // legality steps, each applied once, in order
    function automatic cpc_dec_t cpc_legalise(input cpc_dec_t din, input logic hyb);
        cpc_dec_t d;
        d = din;
        d.reserved = 1'b0;
        if (!d.perms.load_grant) begin
            d.perms.cap_transfer_grant = 1'b0;
        end
        if (!d.perms.load_grant) begin
            d.perms.execute_grant = 1'b0;
        end
        if (d.perms.cap_transfer_grant && !d.perms.load_mutable_grant) begin
            d.perms.store_grant = 1'b0;
        end
        if (!(d.perms.store_grant || d.perms.cap_transfer_grant)) begin
            d.perms.execute_grant = 1'b0;
        end
        if (!d.perms.cap_transfer_grant) begin
            d.perms.load_mutable_grant = 1'b0;
        end
        if (!(d.perms.store_grant || d.perms.load_global_grant)) begin
            d.perms.load_mutable_grant = 1'b0;
        end
        if (!d.perms.load_mutable_grant) begin
            d.perms.load_global_grant = 1'b0;
        end
        if (!(d.perms.load_mutable_grant && d.perms.store_grant)) begin
            d.perms.store_local_grant = 1'b0;
        end
        if (!((d.perms.cap_transfer_grant && d.perms.load_mutable_grant && d.perms.load_global_grant
               && d.perms.store_local_grant)
              || (d.perms.cap_transfer_grant && d.perms.load_mutable_grant && d.perms.load_global_grant
                  && !d.perms.store_grant)
              || !(d.perms.cap_transfer_grant || d.perms.load_mutable_grant || d.perms.load_global_grant
                   || d.perms.store_local_grant))) begin
            d.perms.execute_grant = 1'b0;
        end
        if (!(d.perms.store_grant && d.perms.cap_transfer_grant && d.perms.execute_grant)) begin
            d.perms.sysreg_access_grant = 1'b0;
        end
        if (!(d.perms.execute_grant && hyb)) begin
            d.execution_mode_flag = 1'b0;
        end
        return d;
    endfunction

    // search for the lowest non-reserved encoding whose meaning matches
    function automatic logic [AP_W:0] cpc_encode(input cpc_dec_t want, input logic hyb);
        logic [AP_W:0] res;
        cpc_dec_t d;
        res = '0;
        d = '0;
        for (int i = 0; i < (1 << AP_W); i++) begin
            d = cpc_decode(i[AP_W-1:0], hyb);
            if (!res[AP_W] && !d.reserved && d.perms == want.perms
                && d.execution_mode_flag == want.execution_mode_flag) begin
                res = {1'b1, i[AP_W-1:0]};
            end
        end
        return res;
    endfunction

    // apply byte strobes
    function automatic logic [31:0] cpc_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return m;
    endfunction

    // software registers
    logic hybrid_en;
    logic [AP_W-1:0] cap_ap;
    logic [SWP_W-1:0] cap_swp;
    logic [TYPE_W-1:0] cap_type;
    logic cap_tag;
    logic [BND_W-1:0] cap_bounds;
    logic [31:0] cap_addr;
    logic [10:0] restrict_mask;
    // result registers, then combinational next values
    logic [31:0] read_result;
    logic [31:0] restrict_result;
    logic [31:0] status;
    logic [31:0] next_ctrl;
    logic [31:0] next_cap_perm;
    logic [31:0] next_cap_bounds;
    logic [31:0] next_cap_addr;
    logic [31:0] next_restrict_mask;
    logic [31:0] next_read_result;
    logic [31:0] next_restrict_result;
    logic [31:0] next_status;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // combinational codec paths
    cpc_dec_t cur_dec;
    cpc_dec_t req_dec;
    cpc_dec_t legal_dec;
    logic [AP_W:0] enc;
    logic [AP_W-1:0] inf_ap;
    logic is_null;
    logic is_inf;
    logic access;
    logic mapped;
    logic [31:0] rd_value;

    always_comb begin
        cur_dec = cpc_decode(cap_ap, hybrid_en);
        req_dec = cur_dec;
        req_dec.perms = cpc_perm_t'(cur_dec.perms & restrict_mask[7:0]);
        req_dec.execution_mode_flag = cur_dec.execution_mode_flag & restrict_mask[8];
        legal_dec = cpc_legalise(req_dec, hybrid_en);
        enc = cpc_encode(legal_dec, hybrid_en);
        inf_ap = hybrid_en ? AP_INF_HYB : AP_INF;
        // bounds word holds exponent format, top_recon_bit, mantissa and exponent bits
        is_null = !cap_tag && cap_swp == '0 && cap_ap == '0 && cap_type == '0
                  && cap_bounds == '0 && cap_addr == '0;
        is_inf = cap_tag && cap_swp == SWP_ONES && cap_ap == inf_ap && cap_type == '0
                 && cap_bounds == '0;
    end

    // apb decode and next values
    always_comb begin
        access = psel && penable && pready;
        mapped = 1'b1;
        rd_value = RST_ZERO;
        unique case (paddr)
            OFS_CTRL: rd_value = {31'h0000_0000, hybrid_en};
            OFS_CAP_PERM: rd_value = {23'h00_0000, cap_tag, cap_type, cap_swp, cap_ap};
            OFS_CAP_BOUNDS: rd_value = {8'h00, cap_bounds};
            OFS_CAP_ADDR: rd_value = cap_addr;
            OFS_RESTRICT_MASK: rd_value = {21'h00_0000, restrict_mask};
            OFS_READ_RESULT: rd_value = read_result;
            OFS_RESTRICT_RESULT: rd_value = restrict_result;
            OFS_STATUS: rd_value = status;
            OFS_FORMAT: rd_value = {4'h0, 4'h5, 4'h1, 4'h2, EXP_MAX, MANT_WIDTH};
            OFS_INF_CONST: rd_value = {23'h00_0000, 1'b1, 1'b0, SWP_ONES, inf_ap};
            default: mapped = 1'b0;
        endcase

        next_ctrl = {31'h0000_0000, hybrid_en};
        next_cap_perm = {23'h00_0000, cap_tag, cap_type, cap_swp, cap_ap};
        next_cap_bounds = {8'h00, cap_bounds};
        next_cap_addr = cap_addr;
        next_restrict_mask = {21'h00_0000, restrict_mask};
        if (access && pwrite) begin
            unique case (paddr)
                OFS_CTRL: next_ctrl = cpc_merge(next_ctrl, pwdata, pstrb);
                OFS_CAP_PERM: next_cap_perm = cpc_merge(next_cap_perm, pwdata, pstrb);
                OFS_CAP_BOUNDS: next_cap_bounds = cpc_merge(next_cap_bounds, pwdata, pstrb);
                OFS_CAP_ADDR: next_cap_addr = cpc_merge(next_cap_addr, pwdata, pstrb);
                OFS_RESTRICT_MASK: next_restrict_mask = cpc_merge(next_restrict_mask, pwdata, pstrb);
                default: next_ctrl = {31'h0000_0000, hybrid_en};
            endcase
        end

        // read op: decoded grants, mode, software permissions unchanged
        next_read_result = {15'h0000, cur_dec.reserved, 5'h00, cap_swp,
                            cur_dec.execution_mode_flag, cur_dec.perms};
        next_restrict_result = {15'h0000, !enc[AP_W], 9'h000,
                                cap_swp & restrict_mask[10:9], enc[AP_W-1:0]};
        next_status = {29'h0000_0000, is_inf, is_inf, is_null};

        // zero-wait slave: ready in the first access cycle
        next_pready = psel && !penable;
        next_pslverr = psel && !penable && !mapped;
        next_prdata = (psel && !penable && !pwrite) ? rd_value : RST_ZERO;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hybrid_en <= RST_CTRL[0];
            {cap_tag, cap_type, cap_swp, cap_ap} <= RST_CAP_PERM[8:0];
            cap_bounds <= RST_CAP_BOUNDS[BND_W-1:0];
            cap_addr <= RST_CAP_ADDR;
            restrict_mask <= RST_RESTRICT_MASK[10:0];
            read_result <= RST_ZERO;
            restrict_result <= RST_ZERO;
            status <= RST_ZERO;
            prdata <= RST_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            hybrid_en <= next_ctrl[0];
            {cap_tag, cap_type, cap_swp, cap_ap} <= next_cap_perm[8:0];
            cap_bounds <= next_cap_bounds[BND_W-1:0];
            cap_addr <= next_cap_addr;
            restrict_mask <= next_restrict_mask[10:0];
            read_result <= next_read_result;
            restrict_result <= next_restrict_result;
            status <= next_status;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule // cpc_top

// file: cpc_top_asserts.sv
// checker of the capability permission codec apb answers
`timescale 1ns/10ps
module cpc_top_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cpc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import cpc_pkg::*;
    logic rd_ok;
    assign rd_ok = psel && penable && pready && !pwrite && !pslverr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (psel && !penable |=> pready && penable)
        else $error("no ready in the access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stands longer than one cycle");
    a_unmapped_err: assert property (psel && !penable && (paddr > OFS_INF_CONST || paddr[1:0] != 2'h0)
        |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    a_format_const: assert property (rd_ok && paddr == OFS_FORMAT |-> prdata == 32'h0512_180A)
        else $error("format word wrong");
    a_inf_const: assert property (rd_ok && paddr == OFS_INF_CONST |-> prdata[31:1] == 31'h0000_00B4)
        else $error("infinite constant wrong");
    a_status_excl: assert property (rd_ok && paddr == OFS_STATUS |->
        prdata[2] == prdata[1] && !(prdata[0] && prdata[1]) && prdata[31:3] == 29'h0) else $error("bad status");
    a_resv_none: assert property (rd_ok && paddr == OFS_READ_RESULT && prdata[16] |-> prdata[8:0] == 9'h000)
        else $error("reserved code shows grants");
    a_mode_needs_x: assert property (rd_ok && paddr == OFS_READ_RESULT && prdata[8] |-> prdata[6])
        else $error("mode flag without execute");
    a_enc_legal: assert property (rd_ok && paddr == OFS_RESTRICT_RESULT |-> prdata[16] ? prdata[4:0] == 5'h0
        : (prdata[4:3] == 2'h0 ? !prdata[1] : (prdata[4:3] == 2'h1 || prdata[2:0] inside {3'h3, 3'h6, 3'h7})))
        else $error("restrict gave reserved code");
    c_inf: cover property (rd_ok && paddr == OFS_STATUS && prdata[1]);
    c_null: cover property (rd_ok && paddr == OFS_STATUS && prdata[0]);
    c_err: cover property (pready && pslverr);
endmodule // cpc_top_chk
bind cpc_top cpc_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// file: cpc_host_model.sv
// apb master model standing in for the capability execution pipeline
`timescale 1ns/10ps
module cpc_host_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [cpc_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import cpc_pkg::*;
    // idle bus; non-blocking like every later change of these signals
    initial begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= '0;
        pwdata <= '0;
        pstrb <= 4'h0;
    end
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // cpc_host_model

// file: tb.sv
// self-checking bench of the capability permission codec
`timescale 1ns/10ps
module tb;
    import cpc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, hy;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, d, cp, mk, bd, ad;
    logic [3:0] pstrb;
    logic [9:0] dv;
    logic [5:0] ev;
    int err_total, checked, cyc, sel;
    // decoded grants per code, bit 8 marks a reserved code
    localparam logic [8:0] TBL [32] = '{9'h000, 9'h001, 9'h100, 9'h100, 9'h002, 9'h003, 9'h100, 9'h100,
        9'h0FF, 9'h0FF, 9'h05D, 9'h05D, 9'h07F, 9'h07F, 9'h043, 9'h043,
        9'h100, 9'h100, 9'h100, 9'h005, 9'h100, 9'h100, 9'h02F, 9'h00F,
        9'h100, 9'h100, 9'h100, 9'h01D, 9'h100, 9'h100, 9'h03F, 9'h01F};
    cpc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    cpc_host_model u_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    function automatic logic [9:0] dec(input logic [4:0] ap, input logic h);
        logic m;
        logic r;
        m = (ap[4:3] == 2'h1) && ap[0];
        r = TBL[ap][8] || (m && !h);
        return r ? 10'h200 : {1'b0, m, TBL[ap][7:0]};
    endfunction
    function automatic logic [8:0] rst(input logic [8:0] pm, input logic h);
        logic r, w, c, lm, lg, sl, x, a, m;
        {m, a, x, sl, lg, lm, c, w, r} = pm;
        c = c & r;
        x = x & r;
        w = w & (!c || lm);
        x = x & (w || c);
        lm = lm & c;
        lm = lm & (w || lg);
        lg = lg & lm;
        sl = sl & lm & w;
        x = x & ((c & lm & lg & sl) | (c & lm & lg & !w) | !(c | lm | lg | sl));
        a = a & w & c & x;
        m = m & x & h;
        return {m, a, x, sl, lg, lm, c, w, r};
    endfunction
    function automatic logic [5:0] enc(input logic [8:0] pm, input logic h);
        logic [5:0] res;
        res = 6'h20;
        for (int i = 31; i >= 0; i--) begin
            if (dec(5'(i), h) == {1'b0, pm}) res = {1'b0, 5'(i)};
        end
        return res;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        logic [31:0] q;
        logic e;
        u_host.xfer(1'b1, a, v, 4'hF, q, e);
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] q;
        logic se;
        u_host.xfer(1'b0, a, 32'h0, 4'h0, q, se);
        chk(q, e);
        chk({31'h0, se}, 32'h0);
    endtask
    task automatic end_sim();
        $display("errors=%0d checks=%0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        presetn <= 1'b0;
        err_total = 0;
        checked = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'h3AACC4C9));
        rchk(OFS_RESTRICT_MASK, RST_RESTRICT_MASK);
        rchk(OFS_STATUS, 32'h0000_0001);
        rchk(OFS_FORMAT, 32'h0512_180A);
        // field widths: bits above the capability fields read as zero
        wr(OFS_CAP_PERM, 32'hFFFF_FFFF);
        rchk(OFS_CAP_PERM, 32'h0000_01FF);
        // byte strobes: only lanes 0 and 2 take the new data
        wr(OFS_CAP_ADDR, 32'hFFFF_FFFF);
        u_host.xfer(1'b1, OFS_CAP_ADDR, 32'h1234_5678, 4'h5, d, er);
        chk({31'h0, er}, 32'h0);
        rchk(OFS_CAP_ADDR, 32'hFF34_FF78);
        wr(OFS_CAP_PERM, 32'h0);
        wr(OFS_CAP_ADDR, 32'h0);
        wr(OFS_READ_RESULT, 32'hFFFF_FFFF);
        rchk(OFS_READ_RESULT, 32'h0);
        u_host.xfer(1'b0, 12'h028, 32'h0, 4'h0, d, er);
        chk(d, 32'h0);
        chk({31'h0, er}, 32'h0000_0001);
        for (int h = 0; h < 2; h++) begin
            wr(OFS_CTRL, 32'(h));
            for (int a = 0; a < 32; a++) begin
                cp = {23'h0, 4'($urandom), 5'(a)};
                mk = a[0] ? 32'h0000_07FF : 32'($urandom) & 32'h0000_07FF;
                wr(OFS_CAP_PERM, cp);
                wr(OFS_RESTRICT_MASK, mk);
                rchk(OFS_CAP_PERM, cp);
                dv = dec(cp[4:0], h[0]);
                rchk(OFS_READ_RESULT, {15'h0, dv[9], 5'h0, cp[6:5], dv[8:0]});
                ev = enc(rst(dv[8:0] & mk[8:0], h[0]), h[0]);
                rchk(OFS_RESTRICT_RESULT, {15'h0, ev[5], 9'h0, cp[6:5] & mk[10:9], ev[4:0]});
            end
        end
        for (int k = 0; k < 16; k++) begin
            sel = k % 4;
            hy = 1'($urandom);
            cp = {23'h0, 9'($urandom)};
            bd = (sel == 2) ? 32'h0000_0001 << ($urandom % 24) : 32'h0;
            ad = (sel == 0) ? 32'h0 : $urandom;
            if (sel == 0) cp = 32'h0;
            if (sel == 1 || sel == 2) cp = {23'h0, 2'h2, SWP_ONES, hy ? AP_INF_HYB : AP_INF};
            wr(OFS_CTRL, {31'h0, hy});
            wr(OFS_CAP_PERM, cp);
            wr(OFS_CAP_BOUNDS, bd);
            wr(OFS_CAP_ADDR, ad);
            er = cp[8:0] == {2'h2, SWP_ONES, hy ? AP_INF_HYB : AP_INF} && bd == 32'h0;
            rchk(OFS_STATUS, {29'h0, er, er, cp == 32'h0 && bd == 32'h0 && ad == 32'h0});
            rchk(OFS_INF_CONST, {23'h0, 4'hB, hy ? AP_INF_HYB : AP_INF});
        end
        end_sim();
    end
endmodule // tb
